/* verilog/pra_map.svh */
// register offsets, field positions, reset values and scaling constants
// assumes inclusion by its bare name from the power and alert block
`ifndef PRA_MAP_SVH
`define PRA_MAP_SVH

`define PRA_OFS_CONFIG   8'h00
`define PRA_OFS_POWER    8'h03
`define PRA_OFS_MASK     8'h06
`define PRA_OFS_LIMIT    8'h07

`define PRA_BIT_OVER_CUR  15
`define PRA_BIT_UNDER_CUR 14
`define PRA_BIT_OVER_BUS  13
`define PRA_BIT_UNDER_BUS 12
`define PRA_BIT_OVER_PWR  11
`define PRA_BIT_CNV_SEL   10
`define PRA_BIT_AFF_FLAG  4
`define PRA_BIT_CNV_FLAG  3
`define PRA_BIT_OVF_FLAG  2
`define PRA_BIT_POLARITY  1
`define PRA_BIT_LATCH     0

`define PRA_MASK_RST     16'h0000
`define PRA_LIMIT_RST    16'h0000
`define PRA_POWER_RST    16'h0000
`define PRA_POWER_MAX    16'ha3d7

// power code = i_code * v_code * 1.25 mA * 1.25 mV / 10 mW
// = product / 6400, done as product * ceil(2^40 / 6400) >> 40
`define PRA_POWER_LSB_MW 10
`define PRA_SCALE_MUL    28'ha3d70a4
`define PRA_SCALE_SHIFT  40

`endif

/* verilog/pra_pkg.sv */
// types shared by the power result and alert block
// assumes the constant header pra_map.svh sits beside it
package pra_pkg;

   typedef enum {
      SRC_NONE,
      SRC_CUR_HI,
      SRC_CUR_LO,
      SRC_BUS_HI,
      SRC_BUS_LO,
      SRC_PWR_HI
   } pra_src_type;

   typedef enum {
      PWR_IDLE,
      PWR_MUL,
      PWR_ACC,
      PWR_SCALE
   } pra_pwr_state_type;

endpackage : pra_pkg

/* verilog/pra_top.sv */
// power result register, mask and enable register, alert limit and alert
// assumes results, samples and register strobes come from logic on SYS_CLK
`include "pra_map.svh"

// Function
// - with averaging on, power register holds the averaged power.
// - power code weight is fixed at ten milliwatts per step.
// - power is current code times bus-voltage code.
// - power is stored as a magnitude, whatever the current direction.
// - power never reads above a3d7h.
// - with several limit selects set, only the highest one is compared.
// - over-current select alerts on current above the limit.
// - under-current select alerts on current below the limit.
// - bus over-voltage select alerts on bus voltage above the limit.
// - bus under-voltage select alerts on bus voltage below the limit.
// - power select alerts on power above the limit.
// - conversion-ready select alerts when the ready flag sets.
// - alert-function flag marks that the limit comparison caused the alert.
// - latched, the alert-function flag clears only on a mask read.
// - transparent, the flag clears after a conversion without fault.
// - ready flag sets only once all conversion work is finished.
// - config write clears the ready flag unless it selects power-down.
// - reading the mask and enable register clears the ready flag.
// - power result register readable any time, showing the last result.
// - overflow flag sets when the scaled power exceeds a3d7h and is clamped.
// - alert is active-low by default, active-high with polarity set.
// - transparent alert follows the fault; latched holds until mask read.
// - limit register at 07h, compared in the selected result format.
module pra_top (
   input  wire logic        SYS_CLK,
   input  wire logic        RST_N,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   input  wire logic [7:0]  REG_ADDR,
   input  wire logic [15:0] REG_WDATA,
   output logic      [15:0] REG_RDATA,
   input  wire logic [2:0]  AVG_MODE,
   input  wire logic        SMP_STB,
   input  wire logic [15:0] SMP_CUR,
   input  wire logic [15:0] SMP_BUS,
   input  wire logic        CONV_DONE,
   input  wire logic [15:0] CUR_RESULT,
   input  wire logic [15:0] BUS_RESULT,
   output logic             ALERT_O,
   output logic             ALERT_OE
);
   import pra_pkg::*;

   // number of samples per average is 1 << this
   function automatic logic [3:0] avg_shift(input logic [2:0] m);
      logic [3:0] s;
      s = 4'h0;
      case (m)
         3'h0: s = 4'h0;
         3'h1: s = 4'h2;
         3'h2: s = 4'h4;
         3'h3: s = 4'h6;
         3'h4: s = 4'h7;
         3'h5: s = 4'h8;
         3'h6: s = 4'h9;
         3'h7: s = 4'ha;
         default: s = 4'h0;
      endcase
      return s;
   endfunction : avg_shift

   // highest set select wins
   function automatic pra_src_type pick_src(input logic [15:0] m);
      pra_src_type s;
      s = SRC_NONE;
      if (m[`PRA_BIT_OVER_CUR]) begin
         s = SRC_CUR_HI;
      end else if (m[`PRA_BIT_UNDER_CUR]) begin
         s = SRC_CUR_LO;
      end else if (m[`PRA_BIT_OVER_BUS]) begin
         s = SRC_BUS_HI;
      end else if (m[`PRA_BIT_UNDER_BUS]) begin
         s = SRC_BUS_LO;
      end else if (m[`PRA_BIT_OVER_PWR]) begin
         s = SRC_PWR_HI;
      end
      return s;
   endfunction : pick_src

   logic                    addr_is_mask;
   logic                    mask_read;
   logic                    cfg_write;

   // power path state
   pra_pwr_state_type       pwr_state_reg;
   pra_pwr_state_type       pwr_state_next;
   logic [15:0]             op_cur_reg;
   logic [15:0]             op_cur_next;
   logic [15:0]             op_bus_reg;
   logic [15:0]             op_bus_next;
   logic [31:0]             prod_reg;
   logic [31:0]             prod_next;
   logic [41:0]             acc_reg;
   logic [41:0]             acc_next;
   logic [10:0]             cnt_reg;
   logic [10:0]             cnt_next;
   logic [15:0]             power_reg;
   logic [15:0]             power_next;
   logic                    ovf_reg;
   logic                    ovf_next;
   logic [41:0]             avg_val;
   logic [59:0]             scaled;
   logic [10:0]             last_cnt;

   // flag and register state
   logic [15:0]             mask_reg;
   logic [15:0]             mask_next;
   logic [15:0]             limit_reg;
   logic [15:0]             limit_next;
   logic                    aff_reg;
   logic                    aff_next;
   logic                    conversion_ready_flag_reg;
   logic                    conversion_ready_flag_next;
   logic                    pend_reg;
   logic                    pend_next;
   logic                    alert_oe_reg;
   logic                    alert_oe_next;
   logic [15:0]             rdata_reg;
   logic [15:0]             rdata_next;
   logic                    eval_stb;
   logic                    fault;
   logic                    alert_act;
   logic [15:0]             mask_view;
   pra_src_type             src;

   assign addr_is_mask = (REG_ADDR == `PRA_OFS_MASK);
   assign mask_read    = REG_RD && addr_is_mask;
   // power-down codes are 000 and 100, so the low two mode bits are zero
   assign cfg_write    = REG_WR && (REG_ADDR == `PRA_OFS_CONFIG)
                         && (REG_WDATA[1:0] != 2'h0);

   // power path: magnitude, multiply, accumulate, scale and clamp
   assign last_cnt = 11'(({10'h0, 1'b1} << avg_shift(AVG_MODE)) - 11'h1);
   assign avg_val  = acc_reg >> avg_shift(AVG_MODE);
   // a rounded-up reciprocal keeps every unclamped code an exact floor
   assign scaled   = {28'h0, avg_val[31:0]}
                     * {32'h0, `PRA_SCALE_MUL};

   always_comb begin
      pwr_state_next = pwr_state_reg;
      op_cur_next    = op_cur_reg;
      op_bus_next    = op_bus_reg;
      prod_next      = prod_reg;
      acc_next       = acc_reg;
      cnt_next       = cnt_reg;
      power_next     = power_reg;
      ovf_next       = ovf_reg;
      case (pwr_state_reg)
         PWR_IDLE: begin
            // a sample arriving mid-pipeline is dropped; samples are far
            // apart compared with the four-cycle pipeline
            if (SMP_STB) begin
               op_cur_next = SMP_CUR[15] ? 16'(-SMP_CUR) : SMP_CUR;
               op_bus_next = SMP_BUS;
               pwr_state_next = PWR_MUL;
            end
         end
         PWR_MUL: begin
            prod_next = op_cur_reg * op_bus_reg;
            pwr_state_next = PWR_ACC;
         end
         PWR_ACC: begin
            acc_next = acc_reg + {10'h0, prod_reg};
            if (cnt_reg >= last_cnt) begin
               pwr_state_next = PWR_SCALE;
            end else begin
               cnt_next = cnt_reg + 11'h1;
               pwr_state_next = PWR_IDLE;
            end
         end
         PWR_SCALE: begin
            if (scaled[59:`PRA_SCALE_SHIFT] > {4'h0, `PRA_POWER_MAX}) begin
               power_next = `PRA_POWER_MAX;
               ovf_next   = 1'b1;
            end else begin
               power_next = scaled[`PRA_SCALE_SHIFT +: 16];
               ovf_next   = 1'b0;
            end
            acc_next = 42'h0;
            cnt_next = 11'h0;
            pwr_state_next = PWR_IDLE;
         end
         default: begin
            pwr_state_next = PWR_IDLE;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         pwr_state_reg <= PWR_IDLE;
         op_cur_reg    <= 16'h0000;
         op_bus_reg    <= 16'h0000;
         prod_reg      <= 32'h0000_0000;
         acc_reg       <= 42'h0;
         cnt_reg       <= 11'h0;
         power_reg     <= `PRA_POWER_RST;
         ovf_reg       <= 1'b0;
      end else begin
         pwr_state_reg <= pwr_state_next;
         op_cur_reg    <= op_cur_next;
         op_bus_reg    <= op_bus_next;
         prod_reg      <= prod_next;
         acc_reg       <= acc_next;
         cnt_reg       <= cnt_next;
         power_reg     <= power_next;
         ovf_reg       <= ovf_next;
      end
   end

   // evaluation waits for the power pipeline so the flag never beats it
   assign eval_stb = pend_reg && (pwr_state_reg == PWR_IDLE)
                     && !SMP_STB;

   assign src = pick_src(mask_reg);

   always_comb begin
      fault = 1'b0;
      case (src)
         SRC_CUR_HI: fault = $signed(CUR_RESULT) > $signed(limit_reg);
         SRC_CUR_LO: fault = $signed(CUR_RESULT) < $signed(limit_reg);
         SRC_BUS_HI: fault = BUS_RESULT > limit_reg;
         SRC_BUS_LO: fault = BUS_RESULT < limit_reg;
         SRC_PWR_HI: fault = power_reg > limit_reg;
         SRC_NONE:   fault = 1'b0;
         default:    fault = 1'b0;
      endcase
   end

   assign mask_view = {mask_reg[15:10], 5'h00,
                       aff_reg, conversion_ready_flag_reg, ovf_reg,
                       mask_reg[`PRA_BIT_POLARITY],
                       mask_reg[`PRA_BIT_LATCH]};

   assign alert_act = aff_reg
                      || (mask_reg[`PRA_BIT_CNV_SEL] && conversion_ready_flag_reg);

   always_comb begin
      mask_next  = mask_reg;
      limit_next = limit_reg;
      pend_next  = pend_reg;
      aff_next   = aff_reg;
      conversion_ready_flag_next  = conversion_ready_flag_reg;

      if (REG_WR && addr_is_mask) begin
         mask_next = {REG_WDATA[15:10], 8'h00, REG_WDATA[1:0]};
      end
      if (REG_WR && (REG_ADDR == `PRA_OFS_LIMIT)) begin
         limit_next = REG_WDATA;
      end

      if (CONV_DONE) begin
         pend_next = 1'b1;
      end else if (eval_stb) begin
         pend_next = 1'b0;
      end

      // clears first, so a set in the same cycle wins
      if (mask_read || cfg_write) begin
         conversion_ready_flag_next = 1'b0;
      end
      if (eval_stb) begin
         conversion_ready_flag_next = 1'b1;
      end

      if (mask_reg[`PRA_BIT_LATCH]) begin
         if (mask_read) begin
            aff_next = 1'b0;
         end
         if (eval_stb && fault) begin
            aff_next = 1'b1;
         end
      end else if (eval_stb) begin
         aff_next = fault;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         mask_reg     <= `PRA_MASK_RST;
         limit_reg    <= `PRA_LIMIT_RST;
         pend_reg     <= 1'b0;
         aff_reg      <= 1'b0;
         conversion_ready_flag_reg     <= 1'b0;
      end else begin
         mask_reg     <= mask_next;
         limit_reg    <= limit_next;
         pend_reg     <= pend_next;
         aff_reg      <= aff_next;
         conversion_ready_flag_reg     <= conversion_ready_flag_next;
      end
   end

   // read data holds until the next read, so the host may poll slowly
   always_comb begin
      rdata_next = rdata_reg;
      if (REG_RD) begin
         case (REG_ADDR)
            `PRA_OFS_POWER: rdata_next = power_reg;
            `PRA_OFS_MASK:  rdata_next = mask_view;
            `PRA_OFS_LIMIT: rdata_next = limit_reg;
            default:        rdata_next = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         rdata_reg <= 16'h0000;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // open collector: pull low when the asserted level is low
   always_comb begin
      alert_oe_next = alert_act ^ mask_reg[`PRA_BIT_POLARITY];
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         alert_oe_reg <= 1'b0;
      end else begin
         alert_oe_reg <= alert_oe_next;
      end
   end

   assign REG_RDATA = rdata_reg;
   assign ALERT_O   = 1'b0;
   assign ALERT_OE  = alert_oe_reg;

endmodule : pra_top

/* test/pra_host_model.sv */
// host side of the register port: issues single-word reads and writes
// assumes the bench calls its tasks at a falling edge of clk
module pra_host_model (
   input  wire logic        clk,
   output logic             reg_wr,
   output logic             reg_rd,
   output logic [7:0]       reg_addr,
   output logic [15:0]      reg_wdata,
   input  wire logic [15:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
   end
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      // stale data scrambled so a late capture shows up
      reg_wdata = ~d;
      @(negedge clk);
   endtask : wr
   // n above one holds the strobe for back-to-back reads
   task automatic rd(input logic [7:0] a, input int n, output logic [15:0] d);
      reg_addr = a;
      reg_rd = 1'b1;
      repeat (n) @(negedge clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
      @(negedge clk);
   endtask : rd
endmodule : pra_host_model

/* test/pra_top_assertions.sv */
// port checker for the power result and alert block
// assumes the bind at the foot attaches it to every pra_top
module pra_chk (
   input wire logic        SYS_CLK,
   input wire logic        RST_N,
   input wire logic        REG_WR,
   input wire logic        REG_RD,
   input wire logic [7:0]  REG_ADDR,
   input wire logic [15:0] REG_WDATA,
   input wire logic [15:0] REG_RDATA,
   input wire logic        SMP_STB,
   input wire logic        CONV_DONE,
   input wire logic        ALERT_O,
   input wire logic        ALERT_OE
);
   timeunit 1ns;
   timeprecision 1ps;
   // 8 idle cycles cover the power pipeline plus the alert lag
   logic [3:0] idle_reg;
   logic [3:0] idle_next;
   logic [2:0] sel_reg;
   logic [2:0] sel_next;
   logic       quiet;
   logic       rd_mask;
   always_comb begin
      idle_next = idle_reg + {3'h0, idle_reg != 4'hf};
      if (REG_WR || REG_RD || SMP_STB || CONV_DONE) begin
         idle_next = 4'h0;
      end
      sel_next = sel_reg;
      if (REG_WR && REG_ADDR == 8'h06) begin
         sel_next = {REG_WDATA[10], REG_WDATA[1:0]};
      end
   end
   always_ff @(posedge SYS_CLK) begin
      idle_reg <= RST_N ? idle_next : 4'h0;
      sel_reg  <= RST_N ? sel_next : 3'h0;
   end
   assign quiet   = idle_reg >= 4'h8;
   assign rd_mask = REG_RD && REG_ADDR == 8'h06;
   default clocking @(posedge SYS_CLK);
   endclocking
   default disable iff (!RST_N);
   a_rdata_holds:
      assert property (!REG_RD |=> $stable(REG_RDATA))
      else $error("read data moved without a read");
   a_power_ceiling:
      assert property (REG_RD && REG_ADDR == 8'h03 |=> REG_RDATA <= 16'ha3d7)
      else $error("power above ceiling");
   a_mask_unused:
      assert property (rd_mask |=> REG_RDATA[9:5] == 5'h00)
      else $error("unused mask bits not zero");
   a_ready_clear:
      assert property (quiet && rd_mask ##1 rd_mask |=> !REG_RDATA[3])
      else $error("ready flag kept after mask read");
   a_latch_clear:
      assert property (quiet && sel_reg[0] && rd_mask ##1 rd_mask
                       |=> !REG_RDATA[4])
      else $error("latched alert flag kept after mask read");
   a_alert_steady:
      assert property (quiet |-> $stable(ALERT_OE))
      else $error("alert moved with no cause");
   a_alert_data_low:
      assert property (ALERT_O == 1'b0)
      else $error("alert data not low");
   a_ready_alert:
      assert property (quiet && CONV_DONE && !REG_WR && !SMP_STB
                       && sel_reg[2]
                       ##1 (!REG_RD && !REG_WR && !SMP_STB)[*2]
                       |=> ALERT_OE == !sel_reg[1])
      else $error("ready alert missing");
   a_ready_set:
      assert property (quiet && CONV_DONE && !SMP_STB
                       ##1 (!REG_RD && !REG_WR && !SMP_STB)[*2]
                       ##1 rd_mask |=> REG_RDATA[3])
      else $error("ready flag not set");
   c_double_read: cover property (rd_mask ##1 rd_mask);
   c_ready_read: cover property (CONV_DONE ##3 rd_mask);
   c_power_read: cover property (REG_RD && REG_ADDR == 8'h03);
endmodule : pra_chk

bind pra_top pra_chk chk_u (
   .SYS_CLK(SYS_CLK),
   .RST_N(RST_N),
   .REG_WR(REG_WR),
   .REG_RD(REG_RD),
   .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA),
   .REG_RDATA(REG_RDATA),
   .SMP_STB(SMP_STB),
   .CONV_DONE(CONV_DONE),
   .ALERT_O(ALERT_O),
   .ALERT_OE(ALERT_OE)
);

/* test/tb.sv */
// self-checking bench for the power result and alert block
// assumes pra_top, the host model and the bound checker are compiled first
`define CHK(got, exp) begin \
   samples_checked++; \
   if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
   end \
end

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk;
   logic        rst_n;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   logic [2:0]  avg_mode;
   logic        smp_stb;
   logic [15:0] smp_cur;
   logic [15:0] smp_bus;
   logic        conv_done;
   logic [15:0] cur_result;
   logic [15:0] bus_result;
   logic        alert_o;
   logic        alert_oe;
   logic [15:0] rd_val;
   int          n_mismatch = 0;
   int          samples_checked = 0;
   int          cyc = 0;
   // limit is 100; last entry has both over-current and bus-under set
   logic [15:0] t_mask [6] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000,
                               16'h0800, 16'h9000};
   logic [15:0] t_cur  [6] = '{16'd200, 16'hfffb, 16'd0, 16'd0, 16'd0, 16'd50};
   logic [15:0] t_bus  [6] = '{16'd0, 16'd500, 16'd200, 16'd50, 16'd0, 16'd50};
   logic        t_aff  [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

   pra_top dut_u (
      .SYS_CLK(sys_clk),
      .RST_N(rst_n),
      .REG_WR(reg_wr),
      .REG_RD(reg_rd),
      .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata),
      .REG_RDATA(reg_rdata),
      .AVG_MODE(avg_mode),
      .SMP_STB(smp_stb),
      .SMP_CUR(smp_cur),
      .SMP_BUS(smp_bus),
      .CONV_DONE(conv_done),
      .CUR_RESULT(cur_result),
      .BUS_RESULT(bus_result),
      .ALERT_O(alert_o),
      .ALERT_OE(alert_oe)
   );
   pra_host_model host_u (
      .clk(sys_clk),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata)
   );

   function automatic logic [15:0] pwr_exp(input logic [47:0] p);
      logic [47:0] s;
      // ten milliwatts per code is 6400 steps of current times voltage
      s = p / 48'd6400;
      return (s > 48'ha3d7) ? 16'ha3d7 : s[15:0];
   endfunction : pwr_exp
   task automatic idle(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : idle
   task automatic rdc(input logic [7:0] a, input logic [15:0] e);
      host_u.rd(a, 1, rd_val);
      `CHK(rd_val, e)
   endtask : rdc
   // five idle cycles let the four-stage power pipeline drain
   task automatic smp(input logic [15:0] c, input logic [15:0] b);
      smp_cur = c;
      smp_bus = b;
      smp_stb = 1'b1;
      idle(1);
      smp_stb = 1'b0;
      smp_cur = ~c;
      idle(5);
   endtask : smp
   task automatic conv;
      idle(10);
      conv_done = 1'b1;
      idle(1);
      conv_done = 1'b0;
      idle(2);
   endtask : conv
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 4000) begin
         n_mismatch++;
         report_and_stop();
      end
   end

   initial begin
      rst_n = 1'b0;
      avg_mode = 3'h0;
      smp_stb = 1'b0;
      smp_cur = 16'h0000;
      smp_bus = 16'h0000;
      conv_done = 1'b0;
      cur_result = 16'h0000;
      bus_result = 16'h0000;
      idle(4);
      rst_n = 1'b1;
      rdc(8'h03, 16'h0000);
      rdc(8'h20, 16'h0000);
      `CHK(alert_oe, 1'b0)
      host_u.wr(8'h06, 16'hffff);
      rdc(8'h06, 16'hfc03);
      `CHK(alert_oe, 1'b1)
      host_u.wr(8'h06, 16'h0000);
      smp(16'he0c0, 16'd16000);
      rdc(8'h06, 16'h0000);
      conv();
      rdc(8'h03, pwr_exp(48'd128000000));
      smp(16'h7fff, 16'h7fff);
      conv();
      rdc(8'h03, 16'ha3d7);
      rdc(8'h06, 16'h000c);
      avg_mode = 3'h1;
      smp(16'd1000, 16'd2000);
      smp(16'd2000, 16'd2000);
      smp(16'hf448, 16'd2000);
      smp(16'd4000, 16'd2000);
      conv();
      rdc(8'h03, pwr_exp(48'd5000000));
      // one loud sample among sixteen: a shorter count shows as zero
      avg_mode = 3'h2;
      for (int i = 0; i < 16; i++) begin
         smp((i == 0) ? 16'd3200 : 16'd0, 16'd6400);
      end
      rdc(8'h03, pwr_exp(48'd1280000));
      avg_mode = 3'h0;
      host_u.wr(8'h07, 16'h0064);
      for (int i = 0; i < 6; i++) begin
         host_u.wr(8'h06, t_mask[i]);
         cur_result = t_cur[i];
         bus_result = t_bus[i];
         conv();
         `CHK(alert_oe, t_aff[i])
         rdc(8'h06, t_mask[i] | {11'h0, t_aff[i], 4'h8});
      end
      host_u.wr(8'h06, 16'h8001);
      cur_result = 16'd200;
      conv();
      cur_result = 16'd50;
      conv();
      `CHK(alert_oe, 1'b1)
      idle(9);
      host_u.rd(8'h06, 2, rd_val);
      `CHK(rd_val, 16'h8001)
      `CHK(alert_oe, 1'b0)
      host_u.wr(8'h06, 16'h8000);
      cur_result = 16'd200;
      conv();
      `CHK(alert_oe, 1'b1)
      cur_result = 16'd50;
      conv();
      `CHK(alert_oe, 1'b0)
      rdc(8'h06, 16'h8008);
      host_u.wr(8'h06, 16'h0400);
      `CHK(alert_oe, 1'b0)
      conv();
      `CHK(alert_oe, 1'b1)
      host_u.wr(8'h00, 16'h0007);
      idle(1);
      `CHK(alert_oe, 1'b0)
      conv();
      host_u.wr(8'h00, 16'h0004);
      idle(1);
      `CHK(alert_oe, 1'b1)
      rdc(8'h06, 16'h0408);
      idle(1);
      `CHK(alert_oe, 1'b0)
      host_u.wr(8'h06, 16'h8400);
      cur_result = 16'd200;
      conv();
      rdc(8'h06, 16'h8418);
      idle(1);
      `CHK(alert_oe, 1'b1)
      host_u.wr(8'h06, 16'h0402);
      cur_result = 16'd0;
      conv();
      `CHK(alert_oe, 1'b0)
      report_and_stop();
   end
endmodule : tb
